// [include/frl_map.svh]
// Constants for the frequency reference limiter: reset values, codes and ranges
`ifndef FRL_MAP_SVH
`define FRL_MAP_SVH

// Frequencies are unsigned counts of 0.01 Hz
`define FRL_FREQ_W 16
`define FRL_CODE_W 8
`define FRL_NUM_TERM 11
`define FRL_NUM_BAND 3

// Reset values of the settings store
`define FRL_RST_CLAMP_EN 1'h0
`define FRL_RST_JOG_CLAMP 1'h1
`define FRL_RST_SKIP_EN 1'h0
`define FRL_RST_LOWER_CLAMP 16'h0032
`define FRL_RST_UPPER_CLAMP 16'h1770
`define FRL_RST_FLOOR 16'h0032
`define FRL_RST_CEILING 16'h1770
`define FRL_RST_BAND1_LO 16'h03e8
`define FRL_RST_BAND1_HI 16'h05dc
`define FRL_RST_BAND2_LO 16'h07d0
`define FRL_RST_BAND2_HI 16'h09c4
`define FRL_RST_BAND3_LO 16'h0bb8
`define FRL_RST_BAND3_HI 16'h0dac
`define FRL_RST_PRI_CMD 8'h01
`define FRL_RST_PRI_FREQ 8'h02
`define FRL_RST_PRI_TRQ 8'h00
`define FRL_RST_SEC_CMD 8'h00
`define FRL_RST_SEC_FREQ 8'h00
`define FRL_RST_SEC_TRQ 8'h00
`define FRL_RST_CTRL_MODE 8'h00
`define FRL_RST_TRQ_CTRL 1'h0
`define FRL_RST_KEYPAD_REF 16'h0000
`define FRL_RST_TERM_CFG 8'h00

// Codes
`define FRL_SRC_KEYPAD 8'h00
`define FRL_TERM_SRC_SWITCH 8'h0f
`define FRL_MODE_SENSORLESS 8'h02
`define FRL_MODE_VECTOR 8'h03

// Setting ranges in 0.01 Hz
`define FRL_UPPER_CLAMP_MIN 16'h0032
`define FRL_FLOOR_MIN 16'h0001
`define FRL_FLOOR_MAX 16'h03e8
`define FRL_CEILING_MIN 16'h0fa0
`define FRL_CEILING_MAX 16'h9c40

`endif

// [include/frl_pkg.sv]
// Types shared by the frequency reference limiter
package frl_pkg;

  typedef enum logic [4:0] {
    FRL_P_CLAMP_EN = 5'h00,
    FRL_P_LOWER_CLAMP = 5'h01,
    FRL_P_UPPER_CLAMP = 5'h02,
    FRL_P_JOG_CLAMP = 5'h03,
    FRL_P_FLOOR = 5'h04,
    FRL_P_CEILING = 5'h05,
    FRL_P_SKIP_EN = 5'h06,
    FRL_P_BAND1_LO = 5'h07,
    FRL_P_BAND1_HI = 5'h08,
    FRL_P_BAND2_LO = 5'h09,
    FRL_P_BAND2_HI = 5'h0a,
    FRL_P_BAND3_LO = 5'h0b,
    FRL_P_BAND3_HI = 5'h0c,
    FRL_P_PRI_CMD = 5'h0d,
    FRL_P_PRI_FREQ = 5'h0e,
    FRL_P_PRI_TRQ = 5'h0f,
    FRL_P_SEC_CMD = 5'h10,
    FRL_P_SEC_FREQ = 5'h11,
    FRL_P_SEC_TRQ = 5'h12,
    FRL_P_CTRL_MODE = 5'h13,
    FRL_P_TRQ_CTRL = 5'h14,
    FRL_P_KEYPAD_REF = 5'h15,
    FRL_P_TERM_CFG = 5'h16
  } frl_param_t;

  typedef enum logic [1:0] {
    FRL_WR_IDLE = 2'b00,
    FRL_WR_DONE = 2'b01,
    FRL_WR_REFUSED = 2'b10
  } frl_wr_result_t;

  // Write request from the parameter store front end
  typedef struct packed {
    logic valid;
    frl_param_t sel;
    logic [3:0] index;
    logic [15:0] data;
  } frl_wr_req_t;

  // Selected command, frequency and torque sources
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] freq;
    logic [7:0] trq;
  } frl_sources_t;

  typedef struct packed {
    logic clamp_enable;
    logic jog_clamp_select;
    logic skip_band_enable;
    logic torque_control_enable;
    logic [7:0] control_mode_select;
    logic [15:0] lower_clamp_value;
    logic [15:0] upper_clamp_value;
    logic [15:0] floor_frequency_setting;
    logic [15:0] ceiling_frequency_setting;
    logic [2:0][15:0] band_low;
    logic [2:0][15:0] band_high;
    frl_sources_t primary;
    frl_sources_t secondary;
    logic [15:0] keypad_ref;
    logic [10:0][7:0] term_cfg;
  } frl_settings_t;

  typedef struct packed {
    frl_settings_t set;
    logic [15:0] out_freq;
    frl_sources_t active;
    logic source_switch_function;
    frl_wr_result_t wr_result;
    logic [15:0] rd_data;
  } frl_state_t;

endpackage

// [src/frl_limiter.sv]
// Frequency reference limiter: clamping, skip bands, source switching and its settings store
`timescale 1ns/100ps
`include "frl_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - While clamping is enabled every reference, the keypad one included, is held between lower and upper clamp.
// RULE2 - Clamp enable resets to 0, is turned on with 1, and the clamp values are writable and used only while it is 1.
// RULE3 - The minimum is the lower clamp value when clamping is on and the floor frequency setting when it is off.
// RULE4 - The maximum is the upper clamp value when clamping is on and the ceiling frequency setting when it is off.
// RULE5 - Lower clamp resets to 0.50 Hz within 0..ceiling; upper clamp resets to 60.00 Hz within 0.5 Hz..ceiling.
// RULE6 - With jog clamp select at Yes (reset) jog references are clamped exactly like normal ones when enabled.
// RULE7 - With jog clamp select at No jog skips the clamp values but stays within floor and ceiling.
// RULE8 - With skip bands enabled (reset off) the output stays out of every band when rising and falling.
// RULE9 - Three bands reset to 10-15, 20-25 and 30-35 Hz, each low not above its high, each high not above ceiling.
// RULE10 - A rising reference inside a band holds the output at the band low until it passes above the band.
// RULE11 - A keypad reference that falls inside an enabled skip band is refused.
// RULE12 - A terminal whose configuration code is 15 acts as source switch and selects the secondary command and freq.
// RULE13 - While the source switch is asserted the secondary torque source is used.
// RULE14 - Secondary source writes are refused while running under the primary command source.
// RULE15 - Torque source settings are reachable only in sensorless or vector mode with torque control enabled.
// RULE16 - Sources reset to primary command 1, primary frequency 2 and 0 for all secondary and primary torque.
// RULE17 - A falling reference inside a band holds the output at the band high until it drops below the band.
module frl_limiter (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Settings store write port
  input wire frl_pkg::frl_wr_req_t wr_req,
  output logic wr_done,
  output logic wr_refused,
  // Settings store read port
  input wire frl_pkg::frl_param_t rd_sel,
  input wire logic [3:0] rd_index,
  output logic [15:0] rd_data,
  // Drive status and references
  input wire logic run_active,
  input wire logic jog_active,
  input wire logic [15:0] ext_freq_ref,
  input wire logic [10:0] term_in,
  // Conditioned outputs
  output logic [15:0] out_freq,
  output frl_pkg::frl_sources_t active_sources,
  output logic source_switch_function
);

  frl_pkg::frl_state_t state;
  frl_pkg::frl_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Inclusive band test, used for the output path and for keypad writes
  function automatic logic in_band(input logic [15:0] f, input logic [15:0] lo, input logic [15:0] hi);
    in_band = (f >= lo) && (f <= hi);
  endfunction

  function automatic logic in_any_band(input logic [15:0] f, input frl_pkg::frl_settings_t s);
    logic hit;
    hit = 1'b0;
    for (int b = 0; b < `FRL_NUM_BAND; b++) begin
      hit = hit | in_band(f, s.band_low[b], s.band_high[b]);
    end
    in_any_band = hit;
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] f, input logic [15:0] lo, input logic [15:0] hi);
    if (f < lo) begin
      clamp = lo;
    end else if (f > hi) begin
      clamp = hi;
    end else begin
      clamp = f;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Source switch terminal decode

  logic [10:0] switch_hit;

  generate
    for (genvar t = 0; t < `FRL_NUM_TERM; t++) begin : g_term
      assign switch_hit[t] = term_in[t] && (state.set.term_cfg[t] == `FRL_TERM_SRC_SWITCH); // [RULE12]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency path

  logic switch_now;
  frl_pkg::frl_sources_t sel_sources;
  logic [15:0] raw_ref;
  logic [15:0] min_freq;
  logic [15:0] max_freq;
  logic [15:0] clamped;
  logic [15:0] skipped;
  logic use_clamp_values;

  always_comb begin
    switch_now = |switch_hit;
    sel_sources = switch_now ? state.set.secondary : state.set.primary; // [RULE12] [RULE13]
    // Keypad entry goes through the same clamp as any other source
    raw_ref = (sel_sources.freq == `FRL_SRC_KEYPAD) ? state.set.keypad_ref : ext_freq_ref; // [RULE1]
    use_clamp_values = state.set.clamp_enable && (!jog_active || state.set.jog_clamp_select); // [RULE2] [RULE6] [RULE7]
    min_freq = use_clamp_values ? state.set.lower_clamp_value : state.set.floor_frequency_setting; // [RULE3]
    max_freq = use_clamp_values ? state.set.upper_clamp_value : state.set.ceiling_frequency_setting; // [RULE4]
    clamped = clamp(raw_ref, min_freq, max_freq); // [RULE1] [RULE7]
    skipped = clamped;
    if (state.set.skip_band_enable) begin
      for (int b = 0; b < `FRL_NUM_BAND; b++) begin
        if (in_band(clamped, state.set.band_low[b], state.set.band_high[b])) begin // [RULE8]
          // Direction comes from where the output stood before entering the band
          if (state.out_freq >= state.set.band_high[b]) begin
            skipped = state.set.band_high[b]; // [RULE17]
          end else begin
            skipped = state.set.band_low[b]; // [RULE10]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write checking

  logic wr_ok;
  logic running_primary;
  logic trq_access;
  logic [15:0] wv;
  logic [1:0] band_idx;

  always_comb begin
    wv = wr_req.data;
    band_idx = 2'h0;
    running_primary = run_active && !switch_now;
    trq_access = state.set.torque_control_enable &&
      ((state.set.control_mode_select == `FRL_MODE_SENSORLESS) ||
       (state.set.control_mode_select == `FRL_MODE_VECTOR)); // [RULE15]
    case (wr_req.sel)
      frl_pkg::FRL_P_CLAMP_EN,
      frl_pkg::FRL_P_JOG_CLAMP,
      frl_pkg::FRL_P_SKIP_EN,
      frl_pkg::FRL_P_TRQ_CTRL: begin
        wr_ok = (wv[15:1] == 15'h0000);
      end
      frl_pkg::FRL_P_LOWER_CLAMP: begin
        wr_ok = state.set.clamp_enable && (wv <= state.set.ceiling_frequency_setting); // [RULE2] [RULE5]
      end
      frl_pkg::FRL_P_UPPER_CLAMP: begin
        wr_ok = state.set.clamp_enable && (wv >= `FRL_UPPER_CLAMP_MIN) &&
          (wv <= state.set.ceiling_frequency_setting); // [RULE2] [RULE5]
      end
      frl_pkg::FRL_P_FLOOR: begin
        wr_ok = (wv >= `FRL_FLOOR_MIN) && (wv <= `FRL_FLOOR_MAX);
      end
      frl_pkg::FRL_P_CEILING: begin
        wr_ok = (wv >= `FRL_CEILING_MIN) && (wv <= `FRL_CEILING_MAX);
      end
      frl_pkg::FRL_P_BAND1_LO,
      frl_pkg::FRL_P_BAND2_LO,
      frl_pkg::FRL_P_BAND3_LO: begin
        band_idx = 2'((wr_req.sel - frl_pkg::FRL_P_BAND1_LO) >> 1);
        wr_ok = (wv <= state.set.band_high[band_idx]); // [RULE9]
      end
      frl_pkg::FRL_P_BAND1_HI,
      frl_pkg::FRL_P_BAND2_HI,
      frl_pkg::FRL_P_BAND3_HI: begin
        band_idx = 2'((wr_req.sel - frl_pkg::FRL_P_BAND1_HI) >> 1);
        wr_ok = (wv >= state.set.band_low[band_idx]) && (wv <= state.set.ceiling_frequency_setting); // [RULE9]
      end
      frl_pkg::FRL_P_PRI_CMD,
      frl_pkg::FRL_P_PRI_FREQ,
      frl_pkg::FRL_P_CTRL_MODE: begin
        wr_ok = (wv[15:8] == 8'h00);
      end
      frl_pkg::FRL_P_PRI_TRQ: begin
        wr_ok = trq_access && (wv[15:8] == 8'h00); // [RULE15]
      end
      frl_pkg::FRL_P_SEC_CMD,
      frl_pkg::FRL_P_SEC_FREQ: begin
        wr_ok = !running_primary && (wv[15:8] == 8'h00); // [RULE14]
      end
      frl_pkg::FRL_P_SEC_TRQ: begin
        wr_ok = !running_primary && trq_access && (wv[15:8] == 8'h00); // [RULE14] [RULE15]
      end
      frl_pkg::FRL_P_KEYPAD_REF: begin
        wr_ok = !(state.set.skip_band_enable && in_any_band(wv, state.set)); // [RULE11]
      end
      frl_pkg::FRL_P_TERM_CFG: begin
        wr_ok = (wr_req.index < 4'(`FRL_NUM_TERM)) && (wv[15:8] == 8'h00);
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [15:0] rd_value;

  always_comb begin
    case (rd_sel)
      frl_pkg::FRL_P_CLAMP_EN: rd_value = {15'h0000, state.set.clamp_enable};
      frl_pkg::FRL_P_LOWER_CLAMP: rd_value = state.set.lower_clamp_value;
      frl_pkg::FRL_P_UPPER_CLAMP: rd_value = state.set.upper_clamp_value;
      frl_pkg::FRL_P_JOG_CLAMP: rd_value = {15'h0000, state.set.jog_clamp_select};
      frl_pkg::FRL_P_FLOOR: rd_value = state.set.floor_frequency_setting;
      frl_pkg::FRL_P_CEILING: rd_value = state.set.ceiling_frequency_setting;
      frl_pkg::FRL_P_SKIP_EN: rd_value = {15'h0000, state.set.skip_band_enable};
      frl_pkg::FRL_P_BAND1_LO: rd_value = state.set.band_low[0];
      frl_pkg::FRL_P_BAND1_HI: rd_value = state.set.band_high[0];
      frl_pkg::FRL_P_BAND2_LO: rd_value = state.set.band_low[1];
      frl_pkg::FRL_P_BAND2_HI: rd_value = state.set.band_high[1];
      frl_pkg::FRL_P_BAND3_LO: rd_value = state.set.band_low[2];
      frl_pkg::FRL_P_BAND3_HI: rd_value = state.set.band_high[2];
      frl_pkg::FRL_P_PRI_CMD: rd_value = {8'h00, state.set.primary.cmd};
      frl_pkg::FRL_P_PRI_FREQ: rd_value = {8'h00, state.set.primary.freq};
      frl_pkg::FRL_P_PRI_TRQ: rd_value = {8'h00, state.set.primary.trq};
      frl_pkg::FRL_P_SEC_CMD: rd_value = {8'h00, state.set.secondary.cmd};
      frl_pkg::FRL_P_SEC_FREQ: rd_value = {8'h00, state.set.secondary.freq};
      frl_pkg::FRL_P_SEC_TRQ: rd_value = {8'h00, state.set.secondary.trq};
      frl_pkg::FRL_P_CTRL_MODE: rd_value = {8'h00, state.set.control_mode_select};
      frl_pkg::FRL_P_TRQ_CTRL: rd_value = {15'h0000, state.set.torque_control_enable};
      frl_pkg::FRL_P_KEYPAD_REF: rd_value = state.set.keypad_ref;
      frl_pkg::FRL_P_TERM_CFG: begin
        rd_value = (rd_index < 4'(`FRL_NUM_TERM)) ? {8'h00, state.set.term_cfg[rd_index]} : 16'h0000;
      end
      default: rd_value = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_state = state;
    next_state.out_freq = skipped;
    next_state.active = sel_sources;
    next_state.source_switch_function = switch_now;
    next_state.rd_data = rd_value;
    next_state.wr_result = frl_pkg::FRL_WR_IDLE;
    if (wr_req.valid) begin
      next_state.wr_result = wr_ok ? frl_pkg::FRL_WR_DONE : frl_pkg::FRL_WR_REFUSED;
    end
    if (wr_req.valid && wr_ok) begin
      case (wr_req.sel)
        frl_pkg::FRL_P_CLAMP_EN: next_state.set.clamp_enable = wv[0]; // [RULE2]
        frl_pkg::FRL_P_LOWER_CLAMP: next_state.set.lower_clamp_value = wv;
        frl_pkg::FRL_P_UPPER_CLAMP: next_state.set.upper_clamp_value = wv;
        frl_pkg::FRL_P_JOG_CLAMP: next_state.set.jog_clamp_select = wv[0];
        frl_pkg::FRL_P_FLOOR: next_state.set.floor_frequency_setting = wv;
        frl_pkg::FRL_P_CEILING: next_state.set.ceiling_frequency_setting = wv;
        frl_pkg::FRL_P_SKIP_EN: next_state.set.skip_band_enable = wv[0];
        frl_pkg::FRL_P_BAND1_LO,
        frl_pkg::FRL_P_BAND2_LO,
        frl_pkg::FRL_P_BAND3_LO: next_state.set.band_low[band_idx] = wv;
        frl_pkg::FRL_P_BAND1_HI,
        frl_pkg::FRL_P_BAND2_HI,
        frl_pkg::FRL_P_BAND3_HI: next_state.set.band_high[band_idx] = wv;
        frl_pkg::FRL_P_PRI_CMD: next_state.set.primary.cmd = wv[7:0];
        frl_pkg::FRL_P_PRI_FREQ: next_state.set.primary.freq = wv[7:0];
        frl_pkg::FRL_P_PRI_TRQ: next_state.set.primary.trq = wv[7:0];
        frl_pkg::FRL_P_SEC_CMD: next_state.set.secondary.cmd = wv[7:0];
        frl_pkg::FRL_P_SEC_FREQ: next_state.set.secondary.freq = wv[7:0];
        frl_pkg::FRL_P_SEC_TRQ: next_state.set.secondary.trq = wv[7:0];
        frl_pkg::FRL_P_CTRL_MODE: next_state.set.control_mode_select = wv[7:0];
        frl_pkg::FRL_P_TRQ_CTRL: next_state.set.torque_control_enable = wv[0];
        frl_pkg::FRL_P_KEYPAD_REF: next_state.set.keypad_ref = wv;
        frl_pkg::FRL_P_TERM_CFG: next_state.set.term_cfg[wr_req.index] = wv[7:0];
        default: next_state.set = state.set;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state.set.clamp_enable <= `FRL_RST_CLAMP_EN; // [RULE2]
      state.set.jog_clamp_select <= `FRL_RST_JOG_CLAMP; // [RULE6]
      state.set.skip_band_enable <= `FRL_RST_SKIP_EN; // [RULE8]
      state.set.torque_control_enable <= `FRL_RST_TRQ_CTRL;
      state.set.control_mode_select <= `FRL_RST_CTRL_MODE;
      state.set.lower_clamp_value <= `FRL_RST_LOWER_CLAMP; // [RULE5]
      state.set.upper_clamp_value <= `FRL_RST_UPPER_CLAMP; // [RULE5]
      state.set.floor_frequency_setting <= `FRL_RST_FLOOR;
      state.set.ceiling_frequency_setting <= `FRL_RST_CEILING;
      state.set.band_low <= {`FRL_RST_BAND3_LO, `FRL_RST_BAND2_LO, `FRL_RST_BAND1_LO}; // [RULE9]
      state.set.band_high <= {`FRL_RST_BAND3_HI, `FRL_RST_BAND2_HI, `FRL_RST_BAND1_HI}; // [RULE9]
      state.set.primary <= {`FRL_RST_PRI_CMD, `FRL_RST_PRI_FREQ, `FRL_RST_PRI_TRQ}; // [RULE16]
      state.set.secondary <= {`FRL_RST_SEC_CMD, `FRL_RST_SEC_FREQ, `FRL_RST_SEC_TRQ}; // [RULE16]
      state.set.keypad_ref <= `FRL_RST_KEYPAD_REF;
      state.set.term_cfg <= {`FRL_NUM_TERM{`FRL_RST_TERM_CFG}};
      state.out_freq <= 16'h0000;
      state.active <= {`FRL_RST_PRI_CMD, `FRL_RST_PRI_FREQ, `FRL_RST_PRI_TRQ};
      state.source_switch_function <= 1'h0;
      state.wr_result <= frl_pkg::FRL_WR_IDLE;
      state.rd_data <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign out_freq = state.out_freq;
  assign active_sources = state.active;
  assign source_switch_function = state.source_switch_function;
  assign rd_data = state.rd_data;
  assign wr_done = (state.wr_result == frl_pkg::FRL_WR_DONE);
  assign wr_refused = (state.wr_result == frl_pkg::FRL_WR_REFUSED);

endmodule

// [verif/frl_store_model.sv]
// Parameter store front end model: issues settings writes and reads
`timescale 1ns/100ps
module frl_store_model (
  // Clock
  input wire logic mclk,
  // Write port
  output frl_pkg::frl_wr_req_t wr_req,
  input wire logic wr_done,
  input wire logic wr_refused,
  // Read port
  output frl_pkg::frl_param_t rd_sel,
  output logic [3:0] rd_index,
  input wire logic [15:0] rd_data
);
  initial begin
    wr_req = '0;
    rd_sel = frl_pkg::FRL_P_CLAMP_EN;
    rd_index = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request held up to its taking edge, answer picked up just after that same edge
  task automatic wr(input frl_pkg::frl_param_t s, input logic [3:0] i, input logic [15:0] d,
    output logic [1:0] res);
    @(posedge mclk);
    wr_req <= '{valid: 1'b1, sel: s, index: i, data: d};
    @(posedge mclk);
    wr_req.valid <= 1'b0;
    #1;
    res = {wr_refused, wr_done};
  endtask

  task automatic rd(input frl_pkg::frl_param_t s, input logic [3:0] i, output logic [15:0] v);
    @(posedge mclk);
    rd_sel <= s;
    rd_index <= i;
    @(posedge mclk);
    #1;
    v = rd_data;
  endtask
endmodule

// [verif/frl_limiter_assertions.sv]
// Port-level concurrent checks for the frequency reference limiter
`timescale 1ns/100ps
module frl_limiter_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Write port
  input wire frl_pkg::frl_wr_req_t wr_req,
  input wire logic wr_done,
  input wire logic wr_refused,
  // References and outputs
  input wire logic run_active,
  input wire logic jog_active,
  input wire logic [15:0] ext_freq_ref,
  input wire logic [10:0] term_in,
  input wire logic [15:0] out_freq,
  input wire frl_pkg::frl_sources_t active_sources,
  input wire logic source_switch_function
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Two settled passes make the skip hold idempotent, so three quiet cycles suffice
  sequence quiet_s;
    !wr_req.valid && $stable(ext_freq_ref) && $stable(jog_active) && $stable(term_in);
  endsequence

  one_answer_a: assert property (!(wr_done && wr_refused))
    else $error("write both accepted and refused");
  secondary_lock_a: assert property (run_active && (term_in == 11'h000) && wr_req.valid &&
    (wr_req.sel inside {frl_pkg::FRL_P_SEC_CMD, frl_pkg::FRL_P_SEC_FREQ, frl_pkg::FRL_P_SEC_TRQ}) |=> wr_refused)
    else $error("secondary source changed while running on primary");
  answer_due_a: assert property (wr_req.valid |=> wr_done || wr_refused)
    else $error("write left unanswered");
  answer_asked_a: assert property ((wr_done || wr_refused) |-> $past(wr_req.valid))
    else $error("write answer without request");
  freq_ceiling_a: assert property ($past(nrst) |-> out_freq <= 16'h9c40)
    else $error("output above highest ceiling");
  out_settles_a: assert property (quiet_s [*3] |=> $stable(out_freq))
    else $error("output moved with quiet inputs");
  reset_sources_a: assert property ($rose(nrst) |-> active_sources == 24'h010200 && out_freq == 16'h0000)
    else $error("reset sources wrong");
  switch_cause_a: assert property (source_switch_function |-> $past(term_in) != 11'h000)
    else $error("source switch without terminal");
  sources_hold_a: assert property ((!wr_req.valid && $stable(term_in)) [*2] |=> $stable(active_sources))
    else $error("sources moved with quiet inputs");

  refuse_c: cover property (wr_refused);
  switch_c: cover property ($rose(source_switch_function));
  jog_c: cover property (jog_active && $changed(out_freq));
endmodule

bind frl_limiter frl_limiter_chk chk_u (.mclk, .nrst, .wr_req, .wr_done, .wr_refused, .run_active, .jog_active,
  .ext_freq_ref, .term_in, .out_freq, .active_sources, .source_switch_function);

// [verif/tb_top.sv]
// Self-checking bench for the frequency reference limiter
`timescale 1ns/100ps
module tb_top;
  logic mclk;
  logic nrst;
  logic run_active;
  logic jog_active;
  logic [15:0] ext_freq_ref;
  logic [10:0] term_in;
  frl_pkg::frl_wr_req_t wr_req;
  frl_pkg::frl_param_t rd_sel;
  logic [3:0] rd_index;
  logic wr_done;
  logic wr_refused;
  logic [15:0] rd_data;
  logic [15:0] out_freq;
  frl_pkg::frl_sources_t active_sources;
  logic source_switch_function;
  int failures;
  int n_tests;
  int cyc;

  always #4 mclk = ~mclk;

  frl_limiter dut_u (.mclk, .nrst, .wr_req, .wr_done, .wr_refused, .rd_sel, .rd_index, .rd_data, .run_active,
    .jog_active, .ext_freq_ref, .term_in, .out_freq, .active_sources, .source_switch_function);
  frl_store_model store_u (.mclk, .wr_req, .wr_done, .wr_refused, .rd_sel, .rd_index, .rd_data);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wchk(input frl_pkg::frl_param_t s, input logic [3:0] i, input logic [15:0] d, input logic [1:0] e);
    logic [1:0] res;
    store_u.wr(s, i, d, res);
    check("write answer", {22'h0, res}, {22'h0, e});
  endtask

  // Reference launched on one edge, output settled after the next
  task automatic fchk(input logic [15:0] r, input logic [15:0] e);
    @(posedge mclk);
    ext_freq_ref <= r;
    @(posedge mclk);
    #1;
    check("out_freq", {8'h0, out_freq}, {8'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] d [19] = '{16'h0000, 16'h0032, 16'h1770, 16'h0001, 16'h0032, 16'h1770, 16'h0000, 16'h03e8,
      16'h05dc, 16'h07d0, 16'h09c4, 16'h0bb8, 16'h0dac, 16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] v;
    @(posedge mclk);
    #1;
    check("active_sources", active_sources, 24'h010200);
    for (int k = 0; k < 19; k++) begin
      store_u.rd(frl_pkg::frl_param_t'(k[4:0]), 4'h0, v);
      check("reset value", {8'h0, v}, {8'h0, d[k]});
    end
    $display("t_reset done");
  endtask

  task automatic t_clamp();
    wchk(frl_pkg::FRL_P_LOWER_CLAMP, 4'h0, 16'h03e8, 2'b10);
    wchk(frl_pkg::FRL_P_FLOOR, 4'h0, 16'h03e9, 2'b10);
    wchk(frl_pkg::FRL_P_CEILING, 4'h0, 16'h0f9f, 2'b10);
    fchk(16'h0014, 16'h0032);
    fchk(16'h1b58, 16'h1770);
    wchk(frl_pkg::FRL_P_CLAMP_EN, 4'h0, 16'h0001, 2'b01);
    wchk(frl_pkg::FRL_P_LOWER_CLAMP, 4'h0, 16'h03e8, 2'b01);
    wchk(frl_pkg::FRL_P_UPPER_CLAMP, 4'h0, 16'h0bb8, 2'b01);
    wchk(frl_pkg::FRL_P_UPPER_CLAMP, 4'h0, 16'h0031, 2'b10);
    wchk(frl_pkg::FRL_P_UPPER_CLAMP, 4'h0, 16'h1771, 2'b10);
    fchk(16'h01f4, 16'h03e8);
    fchk(16'h0fa0, 16'h0bb8);
    @(posedge mclk);
    jog_active <= 1'b1;
    fchk(16'h0fa0, 16'h0bb8);
    wchk(frl_pkg::FRL_P_JOG_CLAMP, 4'h0, 16'h0000, 2'b01);
    fchk(16'h0fa0, 16'h0fa0);
    fchk(16'h1b58, 16'h1770);
    fchk(16'h0014, 16'h0032);
    @(posedge mclk);
    jog_active <= 1'b0;
    wchk(frl_pkg::FRL_P_CLAMP_EN, 4'h0, 16'h0000, 2'b01);
    $display("t_clamp done");
  endtask

  task automatic t_skip();
    fchk(16'h04b0, 16'h04b0);
    wchk(frl_pkg::FRL_P_SKIP_EN, 4'h0, 16'h0001, 2'b01);
    fchk(16'h0384, 16'h0384);
    fchk(16'h04b0, 16'h03e8);
    fchk(16'h0640, 16'h0640);
    fchk(16'h04b0, 16'h05dc);
    fchk(16'h08fc, 16'h07d0);
    fchk(16'h0320, 16'h0320);
    wchk(frl_pkg::FRL_P_KEYPAD_REF, 4'h0, 16'h04b0, 2'b10);
    wchk(frl_pkg::FRL_P_KEYPAD_REF, 4'h0, 16'h0dac, 2'b10);
    wchk(frl_pkg::FRL_P_BAND1_LO, 4'h0, 16'h0640, 2'b10);
    wchk(frl_pkg::FRL_P_BAND3_HI, 4'h0, 16'h1771, 2'b10);
    $display("t_skip done");
  endtask

  task automatic t_source();
    logic [15:0] v;
    @(posedge mclk);
    run_active <= 1'b1;
    wchk(frl_pkg::FRL_P_SEC_CMD, 4'h0, 16'h0005, 2'b10);
    wchk(frl_pkg::FRL_P_TERM_CFG, 4'hb, 16'h000f, 2'b10);
    wchk(frl_pkg::FRL_P_TERM_CFG, 4'h3, 16'h000f, 2'b01);
    store_u.rd(frl_pkg::FRL_P_TERM_CFG, 4'h3, v);
    check("term config", {8'h0, v}, 24'h00000f);
    @(posedge mclk);
    term_in <= 11'h008;
    wchk(frl_pkg::FRL_P_SEC_CMD, 4'h0, 16'h0005, 2'b01);
    wchk(frl_pkg::FRL_P_PRI_TRQ, 4'h0, 16'h0001, 2'b10);
    wchk(frl_pkg::FRL_P_CTRL_MODE, 4'h0, 16'h0003, 2'b01);
    wchk(frl_pkg::FRL_P_TRQ_CTRL, 4'h0, 16'h0001, 2'b01);
    wchk(frl_pkg::FRL_P_SEC_TRQ, 4'h0, 16'h0004, 2'b01);
    wchk(frl_pkg::FRL_P_CTRL_MODE, 4'h0, 16'h0002, 2'b01);
    wchk(frl_pkg::FRL_P_PRI_TRQ, 4'h0, 16'h0006, 2'b01);
    wchk(frl_pkg::FRL_P_KEYPAD_REF, 4'h0, 16'h0708, 2'b01);
    fchk(16'h0bb8, 16'h0708);
    // Keypad entry below the lower clamp is lifted to it
    wchk(frl_pkg::FRL_P_CLAMP_EN, 4'h0, 16'h0001, 2'b01);
    wchk(frl_pkg::FRL_P_LOWER_CLAMP, 4'h0, 16'h076c, 2'b01);
    fchk(16'h0bb8, 16'h076c);
    check("switch", {23'h0, source_switch_function}, 24'h000001);
    check("active_sources", active_sources, 24'h050004);
    @(posedge mclk);
    term_in <= 11'h000;
    fchk(16'h0bb8, 16'h0bb8);
    check("active_sources", active_sources, 24'h010206);
    $display("t_source done");
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    run_active = 1'b0;
    jog_active = 1'b0;
    ext_freq_ref = 16'h0000;
    term_in = 11'h000;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_clamp();
    t_skip();
    t_source();
    results();
  end
endmodule
